// >>> serial_pkg.sv
// shared constants and types of the asynchronous serial transceiver
// assumes a 32-bit apb slave port and one 100 mhz core clock
package serial_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] STATUS_OFS = 8'h00;
    localparam logic [7:0] CONTROL_ONE_OFS = 8'h04;
    localparam logic [7:0] SERIAL_CONTROL_TWO_OFS = 8'h08;
    localparam logic [7:0] SHARED_SERIAL_DATA_OFS = 8'h0C;
    localparam logic [7:0] BAUD_OFS = 8'h10;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
    localparam logic [3:0] SAMPLE_FIRST = 4'h7;
    localparam logic [3:0] SAMPLE_LAST = 4'h9;
    localparam logic [1:0] LOW_SPEED_PRESCALE_LAST = 2'h3;
    localparam logic [7:0] BAUD_RESET = 8'h00;

    // ------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------
    typedef struct packed {
        logic serial_master_enable;
        logic nine_bits;
        logic parity_enable;
        logic parity_odd;
        logic two_stops;
        logic send_break;
        logic tx_bit8;
    } control_one_t;

    typedef struct packed {
        logic transmit_enable;
        logic receive_enable;
        logic high_speed;
        logic address_enable;
        logic wake;
        logic rx_irq_enable;
        logic tx_idle_irq_enable;
        logic tx_empty_irq_enable;
    } serial_control_two_t;

    localparam control_one_t CONTROL_ONE_RESET = '0;
    localparam serial_control_two_t CONTROL_TWO_RESET = '0;

    // one-hot receiver states
    typedef enum logic [4:0] {
        RX_IDLE = 5'h01,
        RX_START = 5'h02,
        RX_DATA = 5'h04,
        RX_PARITY = 5'h08,
        RX_STOP = 5'h10
    } rx_state_t;

    // one received character with its error marks
    typedef struct packed {
        logic parity_err;
        logic noise;
        logic framing_err;
        logic [8:0] data;
    } rx_entry_t;

endpackage : serial_pkg

// >>> async_serial_transceiver.sv
// full-duplex asynchronous serial transceiver with apb register access
// assumes an apb master on core_clk and a serial pin pair at the top;
// the receive pin is asynchronous and passes two flops before use
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module async_serial_transceiver (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_in,
    input wire logic lcd_active,
    output logic tx_out,
    output logic tx_oe,
    output logic rx_owned,
    output logic rx_pullup_off,
    output logic irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        serial_pkg::control_one_t c1;
        serial_pkg::serial_control_two_t c2;
        logic [7:0] baud;
        logic [7:0] div_cnt;
        logic [1:0] pre_cnt;
        logic tick;
        logic [8:0] tx_buf;
        logic tx_full;
        logic [11:0] tx_sh;
        logic [3:0] tx_left;
        logic [3:0] tx_ticks;
        logic rx_sync1;
        logic rx_sync2;
        logic rx_prev;
        serial_pkg::rx_state_t rx_st;
        logic [3:0] rx_ticks;
        logic [2:0] rx_smp;
        logic rx_noisy;
        logic [8:0] rx_sh;
        logic [3:0] rx_bits;
        logic rx_par;
        serial_pkg::rx_entry_t [1:0] fifo;
        logic fifo_head;
        logic [1:0] fifo_cnt;
        logic parity_err;
        logic noise;
        logic framing_err;
        logic overrun;
        logic status_seen;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic tx_out;
        logic tx_oe;
        logic rx_owned;
        logic rx_pullup_off;
        logic irq;
    } state_t;

    localparam state_t STATE_RESET = '{
        c1: serial_pkg::CONTROL_ONE_RESET,
        c2: serial_pkg::CONTROL_TWO_RESET,
        baud: serial_pkg::BAUD_RESET,
        rx_sync1: 1'b1,
        rx_sync2: 1'b1,
        rx_prev: 1'b1,
        rx_st: serial_pkg::RX_IDLE,
        tx_out: 1'b1,
        default: '0
    };

    state_t s_q;
    state_t s_d;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic setup;
        logic access;
        logic [7:0] ofs;
        logic tx_on;
        logic rx_on;
        logic tx_busy;
        logic txif;
        logic tidle;
        logic ridle;
        logic maj;
        logic [8:0] rx_data;
        logic push;
        logic pop;
        logic [7:0] status;
        logic [11:0] frame;
        logic rx_pin;
        serial_pkg::rx_entry_t entry;
        setup = psel && !penable;
        access = psel && penable && s_q.pready;
        ofs = paddr[7:0];
        tx_on = s_q.c1.serial_master_enable && s_q.c2.transmit_enable;
        rx_on = s_q.c1.serial_master_enable && s_q.c2.receive_enable;
        tx_busy = s_q.tx_left != 4'h0;
        txif = tx_on && !s_q.tx_full;
        tidle = txif && !tx_busy && !s_q.c1.send_break;
        ridle = s_q.rx_st == serial_pkg::RX_IDLE;
        maj = (s_q.rx_smp[0] & s_q.rx_smp[1]) | (s_q.rx_smp[0] & s_q.rx_smp[2])
            | (s_q.rx_smp[1] & s_q.rx_smp[2]);
        rx_data = s_q.c1.nine_bits ? s_q.rx_sh : {1'b0, s_q.rx_sh[8:1]};
        push = 1'b0;
        pop = 1'b0;
        entry = '0;
        frame = '0;
        rx_pin = s_q.rx_sync2;
        status = {s_q.parity_err, s_q.noise, s_q.framing_err, s_q.overrun,
                  ridle, s_q.fifo_cnt != 2'h0, tidle, txif};
        s_d = s_q;

        // --------------------------------------------------------
        // baud generator: sixteen ticks per bit
        // --------------------------------------------------------
        s_d.tick = 1'b0;
        if (s_q.div_cnt == 8'h00) begin
            s_d.div_cnt = s_q.baud;
            s_d.pre_cnt = s_q.pre_cnt + 2'h1;
            // low speed divides a further four for slow links
            s_d.tick = s_q.c2.high_speed || (s_q.pre_cnt ==
                serial_pkg::LOW_SPEED_PRESCALE_LAST);
        end else begin
            s_d.div_cnt = s_q.div_cnt - 8'h01;
        end

        // receive pin: logic reads the second flop and rx_prev, its copy one cycle later
        s_d.rx_sync1 = rx_in;
        s_d.rx_sync2 = s_q.rx_sync1;
        s_d.rx_prev = s_q.rx_sync2;

        // --------------------------------------------------------
        // transmitter
        // --------------------------------------------------------
        if (!tx_on) begin
            s_d.tx_full = 1'b0;
            s_d.tx_left = 4'h0;
            s_d.tx_ticks = 4'h0;
        end else if (tx_busy) begin
            if (s_q.tick) begin
                s_d.tx_ticks = s_q.tx_ticks + 4'h1;
                if (s_q.tx_ticks == serial_pkg::OVERSAMPLE_LAST) begin
                    s_d.tx_sh = {1'b1, s_q.tx_sh[11:1]};
                    s_d.tx_left = s_q.tx_left - 4'h1;
                end
            end
        end else if (s_q.tx_full && !s_q.c1.send_break) begin
            // frame assembled lsb first behind a low start bit
            frame = {2'b11, s_q.tx_buf, 1'b0};
            if (!s_q.c1.nine_bits) begin
                frame[9] = 1'b1;
            end
            if (s_q.c1.parity_enable) begin
                if (s_q.c1.nine_bits) begin
                    frame[10] = ^s_q.tx_buf ^ s_q.c1.parity_odd;
                end else begin
                    frame[9] = ^s_q.tx_buf[7:0] ^ s_q.c1.parity_odd;
                end
            end
            s_d.tx_sh = frame;
            s_d.tx_left = 4'hA + {3'b000, s_q.c1.nine_bits}
                + {3'b000, s_q.c1.parity_enable}
                + {3'b000, s_q.c1.two_stops};
            s_d.tx_ticks = 4'h0;
            s_d.tx_full = 1'b0;
        end

        // --------------------------------------------------------
        // receiver
        // --------------------------------------------------------
        if (!rx_on) begin
            s_d.rx_st = serial_pkg::RX_IDLE;
        end else if (s_q.rx_st == serial_pkg::RX_IDLE) begin
            if (s_q.rx_prev && !rx_pin) begin
                s_d.rx_st = serial_pkg::RX_START;
                s_d.rx_ticks = 4'h0;
                s_d.rx_noisy = 1'b0;
                s_d.rx_bits = 4'h0;
            end
        end else if (s_q.tick) begin
            s_d.rx_ticks = s_q.rx_ticks + 4'h1;
            if (s_q.rx_ticks >= serial_pkg::SAMPLE_FIRST
                && s_q.rx_ticks <= serial_pkg::SAMPLE_LAST) begin
                s_d.rx_smp = {s_q.rx_smp[1:0], rx_pin};
            end
            if (s_q.rx_ticks == serial_pkg::OVERSAMPLE_LAST) begin
                // three mid-bit samples that disagree mark noise
                if (!(&s_q.rx_smp) && (|s_q.rx_smp)) begin
                    s_d.rx_noisy = 1'b1;
                end
                unique case (s_q.rx_st)
                    serial_pkg::RX_START: begin
                        s_d.rx_st = maj ? serial_pkg::RX_IDLE
                            : serial_pkg::RX_DATA;
                    end
                    serial_pkg::RX_DATA: begin
                        s_d.rx_sh = {maj, s_q.rx_sh[8:1]};
                        s_d.rx_bits = s_q.rx_bits + 4'h1;
                        if (s_q.rx_bits == (s_q.c1.nine_bits ? 4'h8
                            : 4'h7)) begin
                            s_d.rx_st = s_q.c1.parity_enable
                                ? serial_pkg::RX_PARITY : serial_pkg::RX_STOP;
                        end
                    end
                    serial_pkg::RX_PARITY: begin
                        s_d.rx_par = maj;
                        s_d.rx_st = serial_pkg::RX_STOP;
                    end
                    serial_pkg::RX_STOP: begin
                        s_d.rx_st = serial_pkg::RX_IDLE;
                        entry.data = rx_data;
                        entry.framing_err = !maj;
                        entry.noise = s_d.rx_noisy;
                        entry.parity_err = s_q.c1.parity_enable
                            && (s_q.rx_par != (^rx_data ^ s_q.c1.parity_odd));
                        // in address mode only address characters land
                        push = !s_q.c2.address_enable
                            || (s_q.c1.nine_bits ? rx_data[8] : rx_data[7]);
                    end
                    default: begin
                        s_d.rx_st = serial_pkg::RX_IDLE;
                    end
                endcase
            end
        end

        // --------------------------------------------------------
        // register bus
        // --------------------------------------------------------
        s_d.pready = setup;
        s_d.pslverr = 1'b0;
        if (setup) begin
            s_d.prdata = 32'h0000_0000;
            unique case (ofs)
                serial_pkg::STATUS_OFS: s_d.prdata[7:0] = status;
                serial_pkg::CONTROL_ONE_OFS: begin
                    s_d.prdata[7:0] = {s_q.c1[6:1],
                        s_q.fifo[s_q.fifo_head].data[8], 1'b0};
                end
                serial_pkg::SERIAL_CONTROL_TWO_OFS: s_d.prdata[7:0] = s_q.c2;
                serial_pkg::SHARED_SERIAL_DATA_OFS: begin
                    s_d.prdata[7:0] = s_q.fifo[s_q.fifo_head].data[7:0];
                end
                serial_pkg::BAUD_OFS: s_d.prdata[7:0] = s_q.baud;
                default: s_d.pslverr = 1'b1;
            endcase
            if (paddr[1:0] != 2'b00 || paddr[31:8] != 24'h000000) begin
                s_d.pslverr = 1'b1;
            end
        end
        if (access && !s_q.pslverr) begin
            if (ofs == serial_pkg::STATUS_OFS && !pwrite) begin
                s_d.status_seen = 1'b1;
            end
            if (pwrite) begin
                unique case (ofs)
                    serial_pkg::CONTROL_ONE_OFS: begin
                        s_d.c1 = {pwdata[7:2], pwdata[0]};
                    end
                    serial_pkg::SERIAL_CONTROL_TWO_OFS: begin
                        s_d.c2 = pwdata[7:0];
                    end
                    serial_pkg::SHARED_SERIAL_DATA_OFS: begin
                        if (tx_on) begin
                            s_d.tx_buf = {s_q.c1.tx_bit8, pwdata[7:0]};
                            s_d.tx_full = 1'b1;
                        end
                    end
                    serial_pkg::BAUD_OFS: s_d.baud = pwdata[7:0];
                    default: s_d.status_seen = s_d.status_seen;
                endcase
            end
            if (ofs == serial_pkg::SHARED_SERIAL_DATA_OFS) begin
                if (s_q.status_seen) begin
                    s_d.parity_err = 1'b0;
                    s_d.noise = 1'b0;
                    s_d.framing_err = 1'b0;
                    s_d.overrun = 1'b0;
                end
                s_d.status_seen = 1'b0;
                pop = !pwrite && s_q.fifo_cnt != 2'h0;
            end
        end

        // --------------------------------------------------------
        // receive fifo; a new event wins over a clear
        // --------------------------------------------------------
        if (pop) begin
            s_d.fifo_head = !s_q.fifo_head;
        end
        if (push) begin
            // a full fifo, or a pending overrun, blocks new data
            if (s_q.fifo_cnt == 2'h2 || s_q.overrun) begin
                s_d.overrun = 1'b1;
            end else begin
                s_d.fifo[s_q.fifo_head ^ s_q.fifo_cnt[0]] = entry;
                s_d.parity_err = s_d.parity_err | entry.parity_err;
                s_d.noise = s_d.noise | entry.noise;
                s_d.framing_err = s_d.framing_err | entry.framing_err;
            end
        end
        s_d.fifo_cnt = s_q.fifo_cnt
            + {1'b0, push && !s_d.overrun && !s_q.overrun}
            - {1'b0, pop};
        if (!s_q.c1.serial_master_enable) begin
            s_d.fifo_cnt = 2'h0;
        end

        // --------------------------------------------------------
        // pins and interrupt request
        // --------------------------------------------------------
        s_d.tx_oe = tx_on && !lcd_active;
        s_d.tx_out = tx_busy ? s_q.tx_sh[0]
            : !(tx_on && s_q.c1.send_break);
        s_d.rx_owned = rx_on && !lcd_active;
        s_d.rx_pullup_off = rx_on && !lcd_active;
        s_d.irq = (s_q.c2.tx_empty_irq_enable && txif)
            || (s_q.c2.tx_idle_irq_enable && tidle)
            || (s_q.c2.rx_irq_enable && (s_q.fifo_cnt != 2'h0 || s_q.overrun));
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign tx_out = s_q.tx_out;
    assign tx_oe = s_q.tx_oe;
    assign rx_owned = s_q.rx_owned;
    assign rx_pullup_off = s_q.rx_pullup_off;
    assign irq = s_q.irq;

endmodule : async_serial_transceiver

`default_nettype wire

// >>> async_serial_transceiver_monitor.sv
// pin-level assertions for the serial transceiver
// assumes the single core clock and the active-low asynchronous reset
`timescale 1ns/100ps
`default_nettype none

module async_serial_transceiver_monitor (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_in,
    input wire logic lcd_active,
    input wire logic tx_out,
    input wire logic tx_oe,
    input wire logic rx_owned,
    input wire logic rx_pullup_off,
    input wire logic irq
);
    // ----------------------------------------
    // cycles the transmit line held its level
    // ----------------------------------------
    logic last_q;
    logic [7:0] run_q;

    // saturates so a long idle line never wraps into a short run
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            last_q <= 1'b1;
            run_q <= 8'hFF;
        end else begin
            last_q <= tx_out;
            if (tx_out != last_q) begin
                run_q <= 8'h01;
            end else if (run_q != 8'hFF) begin
                run_q <= run_q + 8'h01;
            end
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // ----------------------------------------
    // assertions and covers
    // ----------------------------------------
    setup_then_ready_a: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    ready_single_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    unmapped_err_a: assert property (psel && !penable &&
        (paddr > 32'h10 || paddr[1:0] != 2'h0) |=> pslverr)
        else $error("unmapped access not refused");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    bit_length_a: assert property (tx_out != last_q |-> run_q >= 8'h10)
        else $error("transmit bit shorter than one bit period");
    lcd_owns_a: assert property (lcd_active |=> !tx_oe && !rx_owned)
        else $error("pins claimed while lcd active");
    pullup_off_a: assert property (rx_pullup_off == rx_owned)
        else $error("pull-up control differs from rx ownership");

    cover property ($fell(tx_out));
    cover property (pslverr);
    cover property ($rose(irq));
endmodule : async_serial_transceiver_monitor

bind async_serial_transceiver async_serial_transceiver_monitor mon (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_in(rx_in),
    .lcd_active(lcd_active), .tx_out(tx_out), .tx_oe(tx_oe),
    .rx_owned(rx_owned), .rx_pullup_off(rx_pullup_off), .irq(irq)
);
`default_nettype wire

// >>> serial_peer.sv
// far-side serial device: decodes transmitted frames, sends frames
// assumes the bench sets bit_len and nbits before each exchange
`timescale 1ns/100ps
`default_nettype none

module serial_peer (
    input wire logic core_clk,
    input wire logic tx_line,
    output logic rx_line,
    output logic got,
    output logic [11:0] frame
);
    int bit_len = 16;
    int nbits = 9;
    logic [11:0] acc;

    initial begin
        rx_line = 1'b1;
        got = 1'b0;
        frame = '0;
        forever begin
            @(negedge tx_line);
            repeat (bit_len / 2) @(posedge core_clk);
            if (tx_line === 1'b0) begin
                acc = '0;
                for (int i = 0; i < nbits; i++) begin
                    repeat (bit_len) @(posedge core_clk);
                    acc[i] = tx_line;
                end
                frame <= acc;
                got <= 1'b1;
                @(posedge core_clk);
                got <= 1'b0;
            end
        end
    end

    // frame bits after the start bit, lsb first; line idles high
    task automatic send(input logic [11:0] f, input int n);
        rx_line <= 1'b0;
        repeat (bit_len) @(posedge core_clk);
        for (int i = 0; i < n; i++) begin
            rx_line <= f[i];
            repeat (bit_len) @(posedge core_clk);
        end
        rx_line <= 1'b1;
        @(posedge core_clk);
    endtask : send
endmodule : serial_peer
`default_nettype wire

// >>> async_serial_transceiver_bench.sv
// self-checking bench for the serial transceiver and its far-side peer
// assumes serial_pkg, the design, the peer model and the monitor bind
`timescale 1ns/100ps
`default_nettype none

`define CHECK(what, e, g) \
    begin \
        compares++; \
        if ((g) !== (e)) begin \
            err_total++; \
            $display("mismatch %s exp %h got %h", what, e, g); \
        end \
    end

module async_serial_transceiver_bench;
    logic core_clk = 1'b0;
    logic rst_b, psel, penable, pwrite, pready, pslverr, rx_in, lcd_active;
    logic tx_out, tx_oe, rx_owned, rx_pullup_off, irq, got;
    logic [31:0] paddr, pwdata, prdata, q;
    logic [11:0] frame;
    logic [32:0] exp_q[$];
    logic [32:0] msk_q[$];
    logic [11:0] tx_q[$];
    logic [3:0] pins [5] = '{4'hE, 4'hC, 4'hA, 4'h6, 4'hF};
    logic [5:0] cfg [5] = '{6'h02, 6'h12, 6'h1F, 6'h22, 6'h10};
    logic [8:0] rx_d [3];
    logic [8:0] d;
    logic [3:0] c;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    int seed = 32'hEE51F17E;

    async_serial_transceiver dut (.core_clk(core_clk), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_in(rx_in), .lcd_active(lcd_active),
        .tx_out(tx_out), .tx_oe(tx_oe), .rx_owned(rx_owned),
        .rx_pullup_off(rx_pullup_off), .irq(irq));
    serial_peer peer (.core_clk(core_clk), .tx_line(tx_out),
        .rx_line(rx_in), .got(got), .frame(frame));

    always #5 core_clk = ~core_clk;

    // run lasts a few thousand cycles; the ceiling leaves wide margin
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            test_done();
        end
    end

    // results are taken in order from the notes left by the drivers
    always @(posedge core_clk) begin
        if (psel && penable && pready) begin
            `CHECK("apb", exp_q[0] & msk_q[0], {pslverr, prdata} & msk_q[0])
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
        if (got === 1'b1) begin
            `CHECK("frame", tx_q[0], frame)
            void'(tx_q.pop_front());
        end
    end

    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] dat, input logic [32:0] e, input logic [32:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {24'h0, a};
        pwdata <= dat;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        apb(1'b1, a, dat, 33'h0, {1'b1, 32'h0});
        @(posedge core_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m);
        apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
    endtask : rd

    task automatic poll(input logic [31:0] m);
        int n;
        n = 0;
        do begin
            rd(serial_pkg::STATUS_OFS, 32'h0, 32'h0);
            n++;
        end while ((q & m) == 32'h0 && n < 400);
        `CHECK("status poll", m, q & m)
    endtask : poll

    // c holds nine bits, parity enable, odd parity, two stops
    function automatic logic [11:0] frm(input logic [8:0] v,
        input logic [3:0] k4);
        logic [11:0] f;
        int k;
        f = '0;
        k = k4[3] ? 9 : 8;
        for (int i = 0; i < k; i++) begin
            f[i] = v[i];
        end
        if (k4[2]) begin
            f[k] = ^f[8:0] ^ k4[1];
            k++;
        end
        f[k] = 1'b1;
        f[k + 1] = k4[0];
        return f;
    endfunction : frm

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    initial begin
        {rst_b, psel, penable, pwrite, lcd_active} = 5'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        rd(serial_pkg::CONTROL_ONE_OFS, 32'h0, 32'hFFFFFFFD);
        rd(serial_pkg::SERIAL_CONTROL_TWO_OFS, 32'h0, '1);
        rd(serial_pkg::BAUD_OFS, {24'h0, serial_pkg::BAUD_RESET}, '1);
        apb(1'b0, 8'h14, 32'h0, {1'b1, 32'h0}, {1'b1, 32'h0});
        apb(1'b1, 8'h06, 32'h0, {1'b1, 32'h0}, {1'b1, 32'h0});
        `CHECK("idle pins", 3'h4, {tx_out, tx_oe, irq})
        $display("reset test done");
        for (int i = 0; i < 5; i++) begin
            lcd_active <= pins[i][0];
            wr(serial_pkg::CONTROL_ONE_OFS, {24'h0, pins[i][3], 7'h0});
            wr(serial_pkg::SERIAL_CONTROL_TWO_OFS, {24'h0, pins[i][2:1], 6'h20});
            c[1] = pins[i][3] & pins[i][2] & ~pins[i][0];
            c[0] = pins[i][3] & pins[i][1] & ~pins[i][0];
            `CHECK("pins", {c[1:0], c[0]}, {tx_oe, rx_owned, rx_pullup_off})
        end
        lcd_active <= 1'b0;
        $display("pin test done");
        for (int i = 0; i < 5; i++) begin
            c = cfg[i][5:2];
            peer.bit_len = (cfg[i][1] ? 16 : 64) * (cfg[i][0] + 1);
            peer.nbits = 9 + c[3] + c[2] + c[0];
            d[8] = $random(seed);
            wr(serial_pkg::BAUD_OFS, {31'h0, cfg[i][0]});
            wr(serial_pkg::SERIAL_CONTROL_TWO_OFS, {24'h0, 2'h3, cfg[i][1], 5'h0});
            wr(serial_pkg::CONTROL_ONE_OFS, {24'h0, 1'b1, c, 2'h0, d[8]});
            for (int j = 0; j < 2; j++) begin
                d[7:0] = $random(seed);
                tx_q.push_back(frm(d, c));
                wr(serial_pkg::SHARED_SERIAL_DATA_OFS, {24'h0, d[7:0]});
            end
            for (int n = 0; n < 5000 && tx_q.size() != 0; n++) begin
                @(posedge core_clk);
            end
            `CHECK("tx drained", 0, tx_q.size())
        end
        poll(32'h02);
        `CHECK("tx idle line", 1'b1, tx_out)
        wr(serial_pkg::SERIAL_CONTROL_TWO_OFS, 32'h60);
        wr(serial_pkg::SHARED_SERIAL_DATA_OFS, 32'h5A);
        wr(serial_pkg::SERIAL_CONTROL_TWO_OFS, 32'hE0);
        wr(serial_pkg::BAUD_OFS, 32'h0);
        wr(serial_pkg::CONTROL_ONE_OFS, 32'h80);
        $display("transmit test done");
        peer.bit_len = 16;
        for (int j = 0; j < 3; j++) begin
            rx_d[j] = {1'b0, 8'($random(seed))};
            peer.send(frm(rx_d[j], 4'h0), 9);
        end
        poll(32'h10);
        rd(serial_pkg::STATUS_OFS, 32'h1C, 32'hFC);
        rd(serial_pkg::SHARED_SERIAL_DATA_OFS, rx_d[0], '1);
        rd(serial_pkg::SHARED_SERIAL_DATA_OFS, rx_d[1], '1);
        rd(serial_pkg::STATUS_OFS, 32'h08, 32'hFC);
        wr(serial_pkg::CONTROL_ONE_OFS, 32'hA0);
        for (int j = 0; j < 2; j++) begin
            d = {1'b0, 8'($random(seed))};
            peer.send(frm(d, 4'h4) ^ (12'h100 << j), 10);
            poll(32'h04);
            rd(serial_pkg::STATUS_OFS, 32'h80 >> (2 * j), 32'hA0);
            rd(serial_pkg::SHARED_SERIAL_DATA_OFS, {23'h0, d}, 32'hFF);
        end
        $display("receive test done");
        wr(serial_pkg::CONTROL_ONE_OFS, 32'hC0);
        wr(serial_pkg::SERIAL_CONTROL_TWO_OFS, 32'hF4);
        peer.send(frm(9'h055, 4'h8), 10);
        peer.send(frm(9'h1A5, 4'h8), 10);
        poll(32'h04);
        `CHECK("irq rx", 1'b1, irq)
        rd(serial_pkg::CONTROL_ONE_OFS, 32'h02, 32'h02);
        rd(serial_pkg::SHARED_SERIAL_DATA_OFS, 32'hA5, '1);
        rd(serial_pkg::STATUS_OFS, 32'h0, 32'h04);
        `CHECK("irq clear", 1'b0, irq)
        wr(serial_pkg::SERIAL_CONTROL_TWO_OFS, 32'hE1);
        `CHECK("irq tx empty", 1'b1, irq)
        wr(serial_pkg::SERIAL_CONTROL_TWO_OFS, 32'hE0);
        `CHECK("irq masked", 1'b0, irq)
        $display("interrupt test done");
        test_done();
    end
endmodule : async_serial_transceiver_bench
`default_nettype wire
